/* File: verilog/srer_pkg.sv */
// package for the stream read error reporter: register map, field positions, timing.
// assumes a 100 MHz system clock and a single AHB-Lite master.
package srer_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_ADDR_MID = 8'h0c;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h10;
  localparam logic [7:0] OFS_ERROR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_SECT_CNT = 8'h1c;
  localparam logic [7:0] OFS_ERR_LOG = 8'h20;
  // field positions
  localparam int CTRL_UPPER_HALF_BIT = 0;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CONT_READ_BIT = 1;
  localparam int ERR_COMPLETION_TIMEOUT_FLAG_BIT = 0;
  localparam int ERR_ABORTED_FLAG_BIT = 2;
  localparam int ERR_ADDRESS_NOT_FOUND_FLAG_BIT = 4;
  localparam int ERR_UNC_BIT = 6;
  localparam int STS_ERR_BIT = 0;
  localparam int STS_STREAM_FAULT_BIT = 5;
  localparam int STS_BUSY_BIT = 7;
  // reset values
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_LIMIT_US = 1000;
  localparam int TIME_LIMIT_CYCLES = TIME_LIMIT_US * 1000 / CLK_PERIOD_NS;

  // one error report from the media engine
  typedef struct packed {
    logic valid;
    logic uncorrectable_flag;
    logic address_not_found_flag;
    logic aborted_flag;
    logic [47:0] lba;
    logic [15:0] span;
  } srer_err_evt_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } srer_state_e;
endpackage

/* File: verilog/srer_top.sv */
// stream read error reporter: command-block error registers behind an AHB-Lite slave.
// assumes the media engine reports errors and command completion as one-cycle pulses
// synchronous to CLOCK, and that the master idles between single transfers.
// Overview of operation
// - select clear reads address bits 23:0
// - select set reads address bits 47:24
// - completion time limit sets error bit 0
// - error under continuous read sets status bit 5
// - stream fault: address is first failing sector
// - stream fault: count of suspect consecutive sectors
// - continuous read errors go to log, not error
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module srer_top
  import srer_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = srer_pkg::TIME_LIMIT_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire srer_pkg::srer_err_evt_s ERR_EVENT,
  input wire logic CMD_DONE,
  output logic CMD_ACTIVE
);
  import srer_pkg::*;

  srer_state_e state_q, state_d;
  logic upper_half_q, upper_half_d;
  logic cont_read_q, cont_read_d;
  logic captured_q, captured_d;
  logic [47:0] fail_lba_q, fail_lba_d;
  logic [15:0] fail_span_q, fail_span_d;
  logic [7:0] error_q, error_d;
  logic [7:0] status_q, status_d;
  logic [7:0] log_q, log_d;
  logic [31:0] timer_q, timer_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic wr_pend_q, wr_pend_d;
  logic [31:0] rdata_q, rdata_d;
  logic readyout_q;
  logic active_q, active_d;

  logic addr_phase;
  logic wr_now;
  logic start;
  logic [7:0] evt_bits;
  logic timeout;

  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign wr_now = wr_pend_q;
  assign start = wr_now && (wr_addr_q == OFS_CMD) && HWDATA[CMD_START_BIT];
  assign timeout = (state_q == ST_RUN) && (timer_q >= 32'(TIMEOUT_CYCLES - 1));

  always_comb
  begin
    evt_bits = 8'h00;
    if (ERR_EVENT.valid && state_q == ST_RUN)
    begin
      evt_bits[ERR_UNC_BIT] = ERR_EVENT.uncorrectable_flag;
      evt_bits[ERR_ADDRESS_NOT_FOUND_FLAG_BIT] = ERR_EVENT.address_not_found_flag;
      evt_bits[ERR_ABORTED_FLAG_BIT] = ERR_EVENT.aborted_flag;
    end
    if (timeout)
    begin
      evt_bits[ERR_COMPLETION_TIMEOUT_FLAG_BIT] = 1'b1;
    end
  end

  // command and error capture
  always_comb
  begin
    state_d = state_q;
    cont_read_d = cont_read_q;
    captured_d = captured_q;
    fail_lba_d = fail_lba_q;
    fail_span_d = fail_span_q;
    error_d = error_q;
    status_d = status_q;
    log_d = log_q;
    timer_d = timer_q;
    upper_half_d = upper_half_q;
    if (wr_now && wr_addr_q == OFS_CTRL)
    begin
      upper_half_d = HWDATA[CTRL_UPPER_HALF_BIT];
    end
    case (state_q)
      ST_IDLE, ST_DONE:
      begin
        if (start)
        begin
          state_d = ST_RUN;
          cont_read_d = HWDATA[CMD_CONT_READ_BIT];
          captured_d = 1'b0;
          error_d = ERROR_RESET;
          status_d = STATUS_RESET;
          status_d[STS_BUSY_BIT] = 1'b1;
          log_d = 8'h00;
          timer_d = 32'h0;
        end
      end
      ST_RUN:
      begin
        timer_d = timer_q + 32'h1;
        if (evt_bits != 8'h00 || (ERR_EVENT.valid && !captured_q))
        begin
          if (ERR_EVENT.valid && !captured_q)
          begin
            // only the first failure is kept so the host can restart from it
            captured_d = 1'b1;
            fail_lba_d = ERR_EVENT.lba;
            fail_span_d = ERR_EVENT.span;
          end
          if (cont_read_q && evt_bits != 8'h00)
          begin
            status_d[STS_STREAM_FAULT_BIT] = 1'b1;
            status_d[STS_ERR_BIT] = 1'b0;
            log_d = log_q | evt_bits;
          end
          else if (evt_bits != 8'h00)
          begin
            error_d = error_q | evt_bits;
            status_d[STS_ERR_BIT] = 1'b1;
            status_d[STS_BUSY_BIT] = 1'b0;
            state_d = ST_DONE;
          end
        end
        // a timeout always ends the command, stream or not
        if (timeout || CMD_DONE)
        begin
          status_d[STS_BUSY_BIT] = 1'b0;
          state_d = ST_DONE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // bus slave: zero wait states, read data captured in the address phase
  always_comb
  begin
    wr_pend_d = addr_phase && HWRITE;
    wr_addr_d = addr_phase ? HADDR[7:0] : wr_addr_q;
    rdata_d = 32'h0;
    active_d = (state_d == ST_RUN);
    if (addr_phase && !HWRITE)
    begin
      case (HADDR[7:0])
        OFS_CTRL: rdata_d[CTRL_UPPER_HALF_BIT] = upper_half_q;
        OFS_CMD: rdata_d[CMD_CONT_READ_BIT] = cont_read_q;
        OFS_ADDR_LOW: rdata_d[7:0] = upper_half_q ? fail_lba_q[31:24] : fail_lba_q[7:0];
        OFS_ADDR_MID: rdata_d[7:0] = upper_half_q ? fail_lba_q[39:32] : fail_lba_q[15:8];
        OFS_ADDR_HIGH: rdata_d[7:0] = upper_half_q ? fail_lba_q[47:40] : fail_lba_q[23:16];
        OFS_ERROR: rdata_d[7:0] = error_q;
        OFS_STATUS: rdata_d[7:0] = status_q;
        OFS_SECT_CNT: rdata_d[15:0] = fail_span_q;
        OFS_ERR_LOG: rdata_d[7:0] = log_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= ST_IDLE;
      upper_half_q <= 1'b0;
      cont_read_q <= 1'b0;
      captured_q <= 1'b0;
      fail_lba_q <= 48'h0;
      fail_span_q <= 16'h0;
      error_q <= ERROR_RESET;
      status_q <= STATUS_RESET;
      log_q <= 8'h00;
      timer_q <= 32'h0;
      wr_addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rdata_q <= 32'h0;
      readyout_q <= 1'b0;
      active_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      upper_half_q <= upper_half_d;
      cont_read_q <= cont_read_d;
      captured_q <= captured_d;
      fail_lba_q <= fail_lba_d;
      fail_span_q <= fail_span_d;
      error_q <= error_d;
      status_q <= status_d;
      log_q <= log_d;
      timer_q <= timer_d;
      wr_addr_q <= wr_addr_d;
      wr_pend_q <= wr_pend_d;
      rdata_q <= rdata_d;
      readyout_q <= 1'b1;
      active_q <= active_d;
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = readyout_q;
  assign HRESP = 1'b0 & readyout_q;
  assign CMD_ACTIVE = active_q;
endmodule

/* File: verification/srer_top_asserts.sv */
// checker: bus answer and command timing at the top ports
// assumes it is bound to srer_top from the testbench
`timescale 1ns/1ns
module srer_top_asserts
  import srer_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIME_LIMIT_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic CMD_DONE,
  input wire logic CMD_ACTIVE
);
  import srer_pkg::*;
  int run_q;
  int run_d;
  always_comb run_d = CMD_ACTIVE ? run_q + 1 : 0;
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
      run_q <= 0;
    else
      run_q <= run_d;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  a_resp_okay: assert property (HRESP == 1'b0) else $error("bad response");
  a_zero_wait: assert property ($past(RESET_N) |-> HREADYOUT) else $error("wait state");
  a_rdata_idle: assert property (!$past(HSEL && HTRANS[1] && !HWRITE) |-> HRDATA == 32'h0)
    else $error("read data outside data phase");
  a_time_limit: assert property (run_q <= TIMEOUT_CYCLES + 2)
    else $error("command outlived its time limit");
  a_done_ends_cmd: assert property (CMD_ACTIVE && CMD_DONE |=> !CMD_ACTIVE)
    else $error("command still active after completion");
  // a start written while idle must raise the active flag right after its data phase
  a_start_runs: assert property ((HSEL && HREADY && HTRANS[1] && HWRITE
      && HADDR[7:0] == OFS_CMD && !CMD_ACTIVE) ##1 (HWDATA[CMD_START_BIT] && !CMD_ACTIVE)
      |=> CMD_ACTIVE)
    else $error("start write did not begin a command");
endmodule

/* File: verification/srer_media.sv */
// media engine model: turns bench requests into error reports and completions
// assumes requests come as one-cycle pulses synchronous to CLOCK
`timescale 1ns/1ns
module srer_media
  import srer_pkg::*;
(
  input wire logic CLOCK,
  input wire logic fire,
  input wire logic done_req,
  input wire logic [2:0] flags,
  input wire logic [47:0] lba,
  input wire logic [15:0] span,
  output srer_pkg::srer_err_evt_s ERR_EVENT,
  output logic CMD_DONE
);
  initial {ERR_EVENT, CMD_DONE} = '0;
  // fields toggle outside a report so a stale address never passes for a fresh one
  always @(posedge CLOCK)
  begin
    ERR_EVENT <= fire ? {1'b1, flags, lba, span} : {1'b0, ~ERR_EVENT[66:0]};
    CMD_DONE <= done_req;
  end
endmodule

/* File: verification/testbench.sv */
// testbench: drives the reporter over AHB-Lite and checks register reads
// assumes srer_pkg, srer_top, srer_media and the checker compiled first
`timescale 1ns/1ns
module testbench;
  import srer_pkg::*;
  logic CLOCK = 0, RESET_N = 0, HSEL = 0, HWRITE = 0, rdp = 0, fire = 0, dn = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, s = 32'd26390;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = 3'h2, k = 0;
  logic [47:0] lba = 0;
  logic [15:0] span = 0;
  logic HREADYOUT, HRESP, CMD_DONE, CMD_ACTIVE;
  srer_err_evt_s ev;
  logic [31:0] q[$];
  int mismatches = 0, num_checks = 0;
  srer_top #(.TIMEOUT_CYCLES(50)) DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .ERR_EVENT(ev), .CMD_DONE(CMD_DONE), .CMD_ACTIVE(CMD_ACTIVE));
  srer_media PM (.CLOCK(CLOCK), .fire(fire), .done_req(dn), .flags(k), .lba(lba),
    .span(span), .ERR_EVENT(ev), .CMD_DONE(CMD_DONE));
  initial forever #5 CLOCK = ~CLOCK;
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for the bus answer, or for the command to end
  task automatic wt(logic idle);
    int n;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n++;
    end
    while (!(idle ? CMD_ACTIVE === 1'b0 : HREADYOUT === 1'b1) && n < 200);
    if (n >= 200)
    begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge CLOCK);
    HSEL <= 1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    wt(0);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdp <= !w;
    if (!w)
      q.push_back(d);
    wt(0);
    rdp <= 0;
  endtask
  always @(posedge CLOCK)
    if (rdp && HREADYOUT)
      check(HRDATA, q.pop_front());
  task automatic run(logic c, logic [2:0] f, logic [31:0] st, logic [31:0] er, logic [31:0] lg);
    logic [47:0] first_lba;
    k <= f;
    lba <= {16'(xs()), xs()};
    span <= 16'(xs());
    bus(1, OFS_CMD, {30'h0, c, 1'b1});
    @(posedge CLOCK);
    if (f != 0)
    begin
      fire <= 1;
      @(posedge CLOCK);
      // a later report under continuous read must not move the captured address
      first_lba = lba;
      fire <= c;
      lba <= ~lba;
      @(posedge CLOCK);
      fire <= 0;
      dn <= c;
      @(posedge CLOCK);
      dn <= 0;
    end
    wt(1);
    bus(0, OFS_CMD, 32'(c) << 1);
    bus(0, OFS_STATUS, st);
    bus(0, OFS_ERROR, er);
    if (c)
      bus(0, OFS_ERR_LOG, lg);
    for (int h = 0; h < 2 && f != 0; h++)
    begin
      bus(1, OFS_CTRL, 32'(h));
      bus(0, OFS_CTRL, 32'(h));
      for (int i = 0; i < 3; i++)
        bus(0, OFS_ADDR_LOW + 8'(4 * i), 32'(first_lba[24 * h + 8 * i +: 8]));
    end
    if (c && f != 0)
      bus(0, OFS_SECT_CNT, 32'(span));
  endtask
  initial
  begin
    repeat (20) @(posedge CLOCK);
    RESET_N <= 1;
    @(posedge CLOCK);
    bus(0, OFS_ERROR, 32'(ERROR_RESET));
    bus(0, OFS_STATUS, 32'(STATUS_RESET));
    bus(0, 8'h24, 0);
    for (int i = 0; i < 3; i++)
    begin
      run(0, 3'(4 >> i), 1, 32'h40 >> (2 * i), 0);
      run(1, 3'(4 >> i), 32'h20, 0, 32'h40 >> (2 * i));
    end
    run(0, 0, 1, 1, 0);
    run(1, 0, 32'h20, 0, 1);
    test_done();
  end
endmodule
bind srer_top srer_top_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.CLOCK(CLOCK),
  .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .CMD_DONE(CMD_DONE), .CMD_ACTIVE(CMD_ACTIVE));
